/* core/rwrb_pkg.sv */
// Purpose: Shared constants for the runtime wake register block.
// Assumes: Byte-wide host I/O cycles with a 16-bit address.
// Notes:   Offsets are byte offsets from the programmed block base.

package rwrb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and decode limits.
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 16;
  localparam logic [7:0]  BASE_CFG_IDX  = 8'h30;
  localparam logic [15:0] BASE_MIN      = 16'h0100;
  localparam logic [3:0]  ADDR_TOP_ZERO = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [3:0] OFF_SUMMARY = 4'h0;
  localparam logic [3:0] OFF_GLOBAL  = 4'h1;
  localparam logic [3:0] OFF_STS1    = 4'h2;
  localparam logic [3:0] OFF_STS2    = 4'h3;
  localparam logic [3:0] OFF_STS3    = 4'h4;
  localparam logic [3:0] OFF_EN1     = 4'h5;
  localparam logic [3:0] OFF_EN2     = 4'h6;
  localparam logic [3:0] OFF_EN3     = 4'h7;
  localparam logic [3:0] OFF_MSTS1   = 4'h8;
  localparam logic [3:0] OFF_MSTS2   = 4'h9;
  localparam logic [3:0] OFF_MEN1    = 4'hA;
  localparam logic [3:0] OFF_MEN2    = 4'hB;
  localparam logic [3:0] OFF_GP1     = 4'hC;
  localparam logic [3:0] OFF_GP2     = 4'hD;
  localparam logic [3:0] OFF_GP3     = 4'hE;
  localparam logic [3:0] OFF_GP4     = 4'hF;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and implemented-bit masks.
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_MSTS2     = 8'h01;
  localparam logic [7:0] MASK_SUMMARY  = 8'h01;
  localparam logic [7:0] MASK_GLOBAL   = 8'h01;
  localparam logic [7:0] MASK_STS2     = 8'h7F;
  localparam logic [7:0] MASK_FULL     = 8'hFF;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned SUMMARY_BIT  = 0;
  localparam int unsigned GLOBAL_BIT   = 0;
  localparam int unsigned PPI_BIT      = 0;
  localparam int unsigned GRP1_PINS    = 8;
  localparam int unsigned GRP2_PINS    = 5;
  localparam int unsigned GRP3_PINS    = 8;
  localparam int unsigned SRC2_BITS    = 7;
  localparam int unsigned EVENT_BITS   = 23;

  // Write-one-to-clear update; a hardware set in the same cycle wins.
  function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                          input logic       wr,
                                          input logic [7:0] wdata,
                                          input logic [7:0] set);
    logic [7:0] clr;
    clr = wr ? wdata : 8'h00;
    return (cur & ~clr) | set;
  endfunction

endpackage

/* core/rwrb_edge_detect.sv */
// Purpose: Per-bit active-edge detector for wake sources.
// Assumes: Inputs are synchronous to sys_clk.
// Notes:   invert selects the falling edge instead of the rising one.

`timescale 1ns/1ps
`default_nettype none

module rwrb_edge_detect #(
  parameter int unsigned WIDTH = 23
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Pins and polarity
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] invert,
  // Events
  output logic      [WIDTH-1:0] event_hit
);

  logic [WIDTH-1:0] prev;
  logic             armed;

  ////////////////////////////////////////////////////////////////////////
  // The first sample after reset only primes the history, so a pin that
  // is already high at reset release does not fake an edge.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prev  <= '0;
      armed <= 1'b0;
    end else begin
      prev  <= pins ^ invert;
      armed <= 1'b1;
    end
  end

  assign event_hit = armed ? ((pins ^ invert) & ~prev) : '0;

endmodule

`default_nettype wire

/* core/rwrb_addr_decode.sv */
// Purpose: Host I/O address qualification for the runtime block.
// Assumes: base holds the programmed block base address.
// Notes:   Purely combinational.

`timescale 1ns/1ps
`default_nettype none

module rwrb_addr_decode (
  // Address and base
  input  wire logic [15:0] addr,
  input  wire logic [15:0] base,
  // Result
  output logic             hit,
  output logic [3:0]       offset
);

  logic base_ok;

  // A base below the minimum turns decoding off completely.
  assign base_ok = (base >= rwrb_pkg::BASE_MIN);
  assign hit     = base_ok && (addr[15:12] == rwrb_pkg::ADDR_TOP_ZERO)
                   && (addr[11:4] == base[11:4]);
  assign offset  = addr[3:0];

endmodule

`default_nettype wire

/* core/rwrb_regs.sv */
// Purpose: Runtime wake register block: wake status, enables, management
//          event registers and general data registers.
// Assumes: rst_n is the standby power-on reset; other resets never reach
//          this block. Host cycles are single-cycle strobes.
// Notes:   Reads answer one cycle after the strobe with io_rd_ack.
//
// Notes on behaviour
// - Block base comes from configuration index 0x30; registers sit at base offsets.
// - Address bits 11 to 4 match base bits 11 to 4; upper four bits must be zero.
// - A base below 0x100 disables decoding; host cycles are then ignored.
// - Offsets 00 to 0F hold summary, enables, statuses, management and data.
// - Reserved bits always read as zero.
// - Parallel-port interrupt bit reads 1 unpowered, else follows acknowledge; resets 0x01.
// - Summary bit sets whenever wake would assert, ignoring global enable.
// - Writing 1 clears the summary bit and wake unless a source is still pending; writing 0 does nothing.
// - Global enable bit 0 gates wake output; default 0 blocks it.
// - Summary and global enable reset only by standby power-on reset.
// - Source status sets on its event regardless of any enable.
// - Source status bits are write-one-to-clear; zero writes leave them.
// - Source status registers clear only on standby power-on reset.
// - Status 1 bits 0 to 7 map pins 10 to 17.
// - Status 2: ring one, ring two, pins 20 to 24, bit 7 reserved.
// - Each status register has a bit-matched source enable register.
// - Wake asserts only with status, its enable and global enable set; here it follows summary and global enable and stays asserted until either is cleared.
// - Normal polarity sets on rising pin edge; inverted selects falling edge.
// - Status 3 bits 0 to 7 map pins 30 to 37, write-one-to-clear.

`timescale 1ns/1ps
`default_nettype none

module rwrb_regs (
  // Clock and standby reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Host I/O cycles
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_ack,
  // Block base from configuration space
  input  wire logic [15:0] runtime_base_config,
  // Wake sources
  input  wire logic [7:0]  gpio_group_1,
  input  wire logic [4:0]  gpio_group_2,
  input  wire logic [7:0]  gpio_group_3,
  input  wire logic        ring_indicator_one_n,
  input  wire logic        ring_indicator_two_n,
  input  wire logic [7:0]  polarity_invert_1,
  input  wire logic [4:0]  polarity_invert_2,
  input  wire logic [7:0]  polarity_invert_3,
  // Parallel port state
  input  wire logic        pport_powered,
  input  wire logic        printer_acknowledge_input,
  // Wake output, active low
  output logic             wake_output_n
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic [7:0] wake_summary_status;
  logic [7:0] wake_global_enable;
  logic [7:0] wake_source_status_1;
  logic [7:0] wake_source_status_2;
  logic [7:0] wake_source_status_3;
  logic [7:0] wake_source_enable_1;
  logic [7:0] wake_source_enable_2;
  logic [7:0] wake_source_enable_3;
  logic [7:0] mgmt_event_status_1;
  logic [7:0] mgmt_event_status_2;
  logic [7:0] mgmt_event_enable_1;
  logic [7:0] mgmt_event_enable_2;
  logic [7:0] pin_data_group_1;
  logic [7:0] pin_data_group_2;
  logic [7:0] pin_data_group_3;
  logic [7:0] pin_data_group_4;

  logic        hit;
  logic [3:0]  offset;
  logic        wr_hit;
  logic [22:0] events;
  logic [7:0]  ev1;
  logic [7:0]  ev2;
  logic [7:0]  ev3;
  logic        pending;
  logic [7:0]  next_rdata;
  logic        ppi_level;

  ////////////////////////////////////////////////////////////////////////
  // Address qualification.
  rwrb_addr_decode u_decode (
    .addr   (io_addr),
    .base   (runtime_base_config),
    .hit    (hit),
    .offset (offset)
  );

  assign wr_hit = io_wr && hit;

  ////////////////////////////////////////////////////////////////////////
  // Wake source edges. Ring inputs are active low, so their active
  // transition is the falling edge; the invert term handles that.
  rwrb_edge_detect #(
    .WIDTH (rwrb_pkg::EVENT_BITS)
  ) u_edges (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pins      ({gpio_group_3, gpio_group_2, ring_indicator_two_n, ring_indicator_one_n, gpio_group_1}),
    .invert    ({polarity_invert_3, polarity_invert_2, 2'b11, polarity_invert_1}),
    .event_hit (events)
  );

  assign ev1 = events[7:0];
  assign ev2 = {1'b0, events[14:8]};
  assign ev3 = events[22:15];

  // A source counts as pending when its status and enable are both set.
  assign pending = |(wake_source_status_1 & wake_source_enable_1)
                 | |(wake_source_status_2 & wake_source_enable_2)
                 | |(wake_source_status_3 & wake_source_enable_3);

  ////////////////////////////////////////////////////////////////////////
  // Wake source status registers. Only the standby reset clears them.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_source_status_1 <= rwrb_pkg::RST_ZERO;
      wake_source_status_2 <= rwrb_pkg::RST_ZERO;
      wake_source_status_3 <= rwrb_pkg::RST_ZERO;
    end else begin
      wake_source_status_1 <= rwrb_pkg::w1c_next(wake_source_status_1,
                                wr_hit && offset == rwrb_pkg::OFF_STS1, io_wdata, ev1);
      wake_source_status_2 <= rwrb_pkg::w1c_next(wake_source_status_2,
                                wr_hit && offset == rwrb_pkg::OFF_STS2, io_wdata, ev2)
                              & rwrb_pkg::MASK_STS2;
      wake_source_status_3 <= rwrb_pkg::w1c_next(wake_source_status_3,
                                wr_hit && offset == rwrb_pkg::OFF_STS3, io_wdata, ev3);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary bit. It follows pending sources as a level, so clearing it
  // only sticks once the pending sources' status or enable bits are cleared too.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_summary_status <= rwrb_pkg::RST_ZERO;
    end else begin
      wake_summary_status <= rwrb_pkg::w1c_next(wake_summary_status,
                               wr_hit && offset == rwrb_pkg::OFF_SUMMARY, io_wdata,
                               {7'h00, pending}) & rwrb_pkg::MASK_SUMMARY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable registers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_global_enable   <= rwrb_pkg::RST_ZERO;
      wake_source_enable_1 <= rwrb_pkg::RST_ZERO;
      wake_source_enable_2 <= rwrb_pkg::RST_ZERO;
      wake_source_enable_3 <= rwrb_pkg::RST_ZERO;
    end else if (wr_hit) begin
      if (offset == rwrb_pkg::OFF_GLOBAL) begin
        wake_global_enable <= io_wdata & rwrb_pkg::MASK_GLOBAL;
      end else if (offset == rwrb_pkg::OFF_EN1) begin
        wake_source_enable_1 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_EN2) begin
        wake_source_enable_2 <= io_wdata & rwrb_pkg::MASK_STS2;
      end else if (offset == rwrb_pkg::OFF_EN3) begin
        wake_source_enable_3 <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Management event and general data registers: plain storage here.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mgmt_event_status_1 <= rwrb_pkg::RST_ZERO;
      mgmt_event_status_2 <= rwrb_pkg::RST_MSTS2;
      mgmt_event_enable_1 <= rwrb_pkg::RST_ZERO;
      mgmt_event_enable_2 <= rwrb_pkg::RST_ZERO;
      pin_data_group_1    <= rwrb_pkg::RST_ZERO;
      pin_data_group_2    <= rwrb_pkg::RST_ZERO;
      pin_data_group_3    <= rwrb_pkg::RST_ZERO;
      pin_data_group_4    <= rwrb_pkg::RST_ZERO;
    end else if (wr_hit) begin
      if (offset == rwrb_pkg::OFF_MSTS1) begin
        mgmt_event_status_1 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_MSTS2) begin
        mgmt_event_status_2 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_MEN1) begin
        mgmt_event_enable_1 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_MEN2) begin
        mgmt_event_enable_2 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_GP1) begin
        pin_data_group_1 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_GP2) begin
        pin_data_group_2 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_GP3) begin
        pin_data_group_3 <= io_wdata;
      end else if (offset == rwrb_pkg::OFF_GP4) begin
        pin_data_group_4 <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path. The interrupt bit is live: stuck at one while the port is
  // unpowered, the acknowledge level once it is powered.
  assign ppi_level = pport_powered ? printer_acknowledge_input : 1'b1;

  always_comb begin
    next_rdata = rwrb_pkg::RST_ZERO;
    if (offset == rwrb_pkg::OFF_SUMMARY) begin
      next_rdata = wake_summary_status & rwrb_pkg::MASK_SUMMARY;
    end else if (offset == rwrb_pkg::OFF_GLOBAL) begin
      next_rdata = wake_global_enable & rwrb_pkg::MASK_GLOBAL;
    end else if (offset == rwrb_pkg::OFF_STS1) begin
      next_rdata = wake_source_status_1;
    end else if (offset == rwrb_pkg::OFF_STS2) begin
      next_rdata = wake_source_status_2 & rwrb_pkg::MASK_STS2;
    end else if (offset == rwrb_pkg::OFF_STS3) begin
      next_rdata = wake_source_status_3;
    end else if (offset == rwrb_pkg::OFF_EN1) begin
      next_rdata = wake_source_enable_1;
    end else if (offset == rwrb_pkg::OFF_EN2) begin
      next_rdata = wake_source_enable_2 & rwrb_pkg::MASK_STS2;
    end else if (offset == rwrb_pkg::OFF_EN3) begin
      next_rdata = wake_source_enable_3;
    end else if (offset == rwrb_pkg::OFF_MSTS1) begin
      next_rdata = mgmt_event_status_1;
    end else if (offset == rwrb_pkg::OFF_MSTS2) begin
      next_rdata = mgmt_event_status_2;
      next_rdata[rwrb_pkg::PPI_BIT] = ppi_level;
    end else if (offset == rwrb_pkg::OFF_MEN1) begin
      next_rdata = mgmt_event_enable_1;
    end else if (offset == rwrb_pkg::OFF_MEN2) begin
      next_rdata = mgmt_event_enable_2;
    end else if (offset == rwrb_pkg::OFF_GP1) begin
      next_rdata = pin_data_group_1;
    end else if (offset == rwrb_pkg::OFF_GP2) begin
      next_rdata = pin_data_group_2;
    end else if (offset == rwrb_pkg::OFF_GP3) begin
      next_rdata = pin_data_group_3;
    end else begin
      next_rdata = pin_data_group_4;
    end
  end

  // Reads only capture data; no register changes on a read.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_rdata  <= rwrb_pkg::RST_ZERO;
      io_rd_ack <= 1'b0;
    end else begin
      io_rd_ack <= io_rd && hit;
      io_rdata  <= (io_rd && hit) ? next_rdata : rwrb_pkg::RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake output, gated by the global enable.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_output_n <= 1'b1;
    end else begin
      wake_output_n <= ~(wake_summary_status[rwrb_pkg::SUMMARY_BIT]
                         & wake_global_enable[rwrb_pkg::GLOBAL_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  low_base_off_a: assert property ((io_rd && runtime_base_config < rwrb_pkg::BASE_MIN) |=> !io_rd_ack)
    else $error("read answered with base below minimum");
  top_nibble_a: assert property ((io_rd && io_addr[15:12] != 4'h0) |=> !io_rd_ack)
    else $error("read answered with upper address bits set");
  read_answer_a: assert property ((io_rd && runtime_base_config >= rwrb_pkg::BASE_MIN
                                   && io_addr[15:12] == 4'h0
                                   && io_addr[11:4] == runtime_base_config[11:4]) |=> io_rd_ack)
    else $error("qualified read not answered");
  reserved_zero_a: assert property ((io_rd && hit && offset == rwrb_pkg::OFF_SUMMARY)
                                    |=> io_rdata[7:1] == 7'h00)
    else $error("reserved summary bits read nonzero");
  event_sets_a: assert property (ev1[0] |=> wake_source_status_1[0])
    else $error("source event did not set status");
  w1c_clear_a: assert property ((wr_hit && offset == rwrb_pkg::OFF_STS1 && io_wdata[0] && !ev1[0])
                                |=> !wake_source_status_1[0])
    else $error("write one did not clear status");
  summary_set_a: assert property (pending |=> wake_summary_status[0])
    else $error("summary bit missed a pending source");
  zero_keeps_a: assert property ((wr_hit && offset == rwrb_pkg::OFF_SUMMARY && !io_wdata[0]
                                  && wake_summary_status[0]) |=> wake_summary_status[0])
    else $error("writing zero changed summary");
  wake_gated_a: assert property (!wake_output_n |-> $past(wake_global_enable[0]))
    else $error("wake asserted without global enable");
  ppi_idle_a: assert property ((io_rd && hit && offset == rwrb_pkg::OFF_MSTS2 && !pport_powered)
                               |=> io_rdata[rwrb_pkg::PPI_BIT])
    else $error("interrupt bit not one while unpowered");

  wake_seen_c: cover property ($fell(wake_output_n));
  summary_clr_c: cover property (wr_hit && offset == rwrb_pkg::OFF_SUMMARY && io_wdata[0]
                                 ##1 !wake_summary_status[0]);
  ring_event_c: cover property (ev2[0] ##1 wake_source_status_2[0]);

endmodule

`default_nettype wire

/* bench/rwrb_host_model.sv */
// Purpose: Host chipset model that issues byte I/O cycles to the runtime block.
// Assumes: Requests change just after a rising edge of sys_clk.
// Notes:   An idle address or data bus shows the inverse of its last value.

`timescale 1ns/1ps
`default_nettype none

module rwrb_host_model (
  // Clock
  input  wire logic        sys_clk,
  // Host I/O cycles
  output var  logic [15:0] io_addr,
  output var  logic [7:0]  io_wdata,
  output var  logic        io_wr,
  output var  logic        io_rd,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rd_ack
);
  initial begin
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One byte per strobe, never a read and a write together.
  task automatic write_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    io_addr  <= ~a;
    io_wdata <= ~d;
  endtask

  // The answer stands in the cycle after the strobe and is taken at its closing edge.
  task automatic read_byte(input logic [15:0] a, output logic [7:0] d, output logic ack);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
    io_addr <= ~a;
    @(posedge sys_clk);
    d   = io_rdata;
    ack = io_rd_ack;
  endtask
endmodule

`default_nettype wire

/* bench/tb_runtime_wake_register_block.sv */
// Purpose: Self-checking bench for the runtime wake register block.
// Assumes: The host model drives all I/O cycles; the bench drives pins.
// Notes:   Base sits on a 16-byte boundary inside the legal I/O range.

`timescale 1ns/1ps
`default_nettype none

module tb_runtime_wake_register_block;
  localparam logic [15:0] BASE = 16'h0A40;
  localparam logic [7:0] EXP_FF [16] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'hFF,
                                         8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic        sys_clk;
  logic        rst_n;
  logic [15:0] io_addr;
  logic [15:0] runtime_base_config;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_wr;
  logic        io_rd;
  logic        io_rd_ack;
  logic [7:0]  gpio_group_1;
  logic [4:0]  gpio_group_2;
  logic [7:0]  gpio_group_3;
  logic        ring_indicator_one_n;
  logic        ring_indicator_two_n;
  logic [7:0]  polarity_invert_1;
  logic [4:0]  polarity_invert_2;
  logic [7:0]  polarity_invert_3;
  logic        pport_powered;
  logic        printer_acknowledge_input;
  logic        wake_output_n;
  logic [7:0]  rd_d;
  logic        rd_ack;
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;

  rwrb_regs rwrb_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
    .runtime_base_config(runtime_base_config), .gpio_group_1(gpio_group_1), .gpio_group_2(gpio_group_2),
    .gpio_group_3(gpio_group_3), .ring_indicator_one_n(ring_indicator_one_n),
    .ring_indicator_two_n(ring_indicator_two_n), .polarity_invert_1(polarity_invert_1),
    .polarity_invert_2(polarity_invert_2), .polarity_invert_3(polarity_invert_3),
    .pport_powered(pport_powered), .printer_acknowledge_input(printer_acknowledge_input),
    .wake_output_n(wake_output_n));

  rwrb_host_model rwrb_host_model_inst (.sys_clk(sys_clk), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] off, input logic [7:0] exp);
    rwrb_host_model_inst.read_byte(BASE | {12'h000, off}, rd_d, rd_ack);
    check({7'h00, rd_ack}, 8'h01);
    check(rd_d, exp);
  endtask

  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    rwrb_host_model_inst.write_byte(BASE | {12'h000, off}, d);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // A full run needs a few hundred cycles; the ceiling leaves wide margin.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    rst_n                     = 1'b0;
    runtime_base_config       = BASE;
    gpio_group_1              = 8'h00;
    gpio_group_2              = 5'h00;
    gpio_group_3              = 8'hFF;
    ring_indicator_one_n      = 1'b1;
    ring_indicator_two_n      = 1'b1;
    polarity_invert_1         = 8'h00;
    polarity_invert_2         = 5'h00;
    polarity_invert_3         = 8'h0F;
    pport_powered             = 1'b0;
    printer_acknowledge_input = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++) rchk(i[3:0], (i == 9) ? 8'h01 : 8'h00);
    for (int i = 0; i < 16; i++) wr(i[3:0], 8'hFF);
    for (int i = 0; i < 16; i++) rchk(i[3:0], EXP_FF[i]);
    wr(4'h1, 8'h00);
    gpio_group_1         <= 8'hA5;
    gpio_group_2         <= 5'h1F;
    gpio_group_3         <= 8'h00;
    ring_indicator_one_n <= 1'b0;
    ring_indicator_two_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(4'h2, 8'hA5);
    rchk(4'h3, 8'h7F);
    rchk(4'h4, 8'h0F);
    rchk(4'h0, 8'h01);
    check({7'h00, wake_output_n}, 8'h01);
    wr(4'h1, 8'h01);
    repeat (3) @(posedge sys_clk);
    check({7'h00, wake_output_n}, 8'h00);
    wr(4'h2, 8'h00);
    rchk(4'h2, 8'hA5);
    wr(4'h2, 8'h05);
    rchk(4'h2, 8'hA0);
    wr(4'h0, 8'h01);
    rchk(4'h0, 8'h01);
    wr(4'h2, 8'hFF);
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'hFF);
    rchk(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    repeat (2) @(posedge sys_clk);
    rchk(4'h0, 8'h00);
    check({7'h00, wake_output_n}, 8'h01);
    rwrb_host_model_inst.write_byte(BASE | 16'h1005, 8'h00);
    rwrb_host_model_inst.read_byte(BASE | 16'h1005, rd_d, rd_ack);
    check({7'h00, rd_ack}, 8'h00);
    rwrb_host_model_inst.read_byte(BASE + 16'h0015, rd_d, rd_ack);
    check({7'h00, rd_ack}, 8'h00);
    runtime_base_config <= 16'h00F0;
    rwrb_host_model_inst.write_byte(16'h00F5, 8'h00);
    rwrb_host_model_inst.read_byte(16'h00F5, rd_d, rd_ack);
    check({7'h00, rd_ack}, 8'h00);
    runtime_base_config <= BASE;
    rchk(4'h5, 8'hFF);
    pport_powered <= 1'b1;
    rchk(4'h9, 8'hFE);
    printer_acknowledge_input <= 1'b1;
    rchk(4'h9, 8'hFF);
    // A second standby reset with the pins held at new levels must not fake edges.
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rchk(4'h2, 8'h00);
    rchk(4'h3, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h9, 8'h01);
    wr(4'h1, 8'h01);
    gpio_group_1 <= 8'h5A;
    rchk(4'h2, 8'h5A);
    rchk(4'h0, 8'h00);
    check({7'h00, wake_output_n}, 8'h01);
    summarize();
  end
endmodule

`default_nettype wire
